/* File: dstb_pkg.sv */
// Shared constants, register map and types of the decrementing scan timer bank
package dstb_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bank geometry
	localparam int TIMER_COUNT = 256;                 // Timers numbered 0 to 255
	localparam int NUM_W       = 8;                   // Width of a timer number
	localparam int VAL_W       = 16;                  // Width of set and present values

	////////////////////////////////////////////////////////////////////////////////
	// Time base
	localparam int CLK_PERIOD_NS  = 100;                          // System clock period
	localparam int TEN_MS_NS      = 10_000_000;                   // Finest time unit
	localparam int HUNDRED_MS_NS  = 100_000_000;                  // Main timer unit
	localparam int TICK_CYCLES    = TEN_MS_NS / CLK_PERIOD_NS;    // Clocks per 10 ms tick
	localparam int TICKS_PER_UNIT = HUNDRED_MS_NS / TEN_MS_NS;    // 10 ms ticks per 100 ms
	localparam logic [15:0] TICKS_PER_UNIT_W = 16'(TICKS_PER_UNIT);

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;  // Mode and hold control
	localparam logic [7:0] OFS_SETVAL = 8'h04;  // Set value / move operand
	localparam logic [7:0] OFS_CMD    = 8'h08;  // Instruction launch, write only
	localparam logic [7:0] OFS_STATUS = 8'h0C;  // Result of last instruction
	localparam logic [7:0] OFS_TICK   = 8'h10;  // Free-running 10 ms tick count

	////////////////////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int CTRL_W          = 3;
	localparam int CTRL_HOLD_BIT   = 0;   // memory_hold_bit
	localparam int CTRL_PROT_BIT   = 1;   // Hold bit protected in setup
	localparam int CTRL_RUN_BIT    = 2;   // 1 run/monitor, 0 program
	localparam logic [2:0] CTRL_RESET = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Command register fields
	localparam int CMD_NUM_LSB    = 0;
	localparam int CMD_INPUT_BIT  = 8;    // Timer start input
	localparam int CMD_BINARY_BIT = 9;    // 1 binary, 0 BCD
	localparam int CMD_TENMS_BIT  = 10;   // 1 ten_ms variant, 0 hundred_ms
	localparam int CMD_ILOCK_BIT  = 11;   // Inside active interlock section
	localparam int CMD_JUMP_BIT   = 12;   // Inside skipped jump section
	localparam int CMD_OP_LSB     = 16;
	localparam int CMD_OP_W       = 3;

	// Instruction codes
	typedef enum logic [2:0] {
		OP_EXECUTE     = 3'h0,
		OP_RESET_INSTR = 3'h1,
		OP_FORCE_SET   = 3'h2,
		OP_FORCE_RESET = 3'h3,
		OP_MOVE_WORD   = 3'h4,
		OP_QUERY       = 3'h5
	} dstb_op_type;

	////////////////////////////////////////////////////////////////////////////////
	// Status register fields
	localparam int STAT_DONE_BIT = 16;
	localparam int STAT_ERR_BIT  = 17;

	////////////////////////////////////////////////////////////////////////////////
	// Values
	localparam logic [15:0] PV_ZERO = 16'h0000;
	localparam logic [15:0] BCD_MAX = 16'h9999;
	localparam logic [15:0] BIN_MAX = 16'hFFFF;
	localparam logic [3:0]  BE_ALL  = 4'hF;

	// Bus handshake states
	typedef enum logic {
		BUS_WAIT = 1'b0,
		BUS_ACK  = 1'b1
	} dstb_bus_type;

endpackage

/* File: dstb_tick_base.sv */
// Free-running 10 ms tick counter shared by every timer
`timescale 1ns/1ps
module dstb_tick_base
	import dstb_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES            // Clocks per tick
) (
	input  wire logic        clk_sys,             // System clock
	input  wire logic        rst_n,               // Async reset, low
	output logic      [15:0] tick_count           // Ticks since reset, wraps
);

	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] div_r;       // Clock divider
	logic [CW-1:0] div_nxt;
	logic [15:0]   tick_r;      // Tick counter
	logic [15:0]   tick_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Divide the clock down to one count per 10 ms
	always_comb begin
		div_nxt  = div_r + CW'(1);
		tick_nxt = tick_r;
		if (div_r == LAST) begin
			div_nxt  = '0;
			tick_nxt = tick_r + 16'h0001;
		end
	end

	// Register the divider
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_r  <= '0;
			tick_r <= 16'h0000;
		end else begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_count = tick_r;

endmodule // dstb_tick_base

/* File: dstb_timer_bank.sv */
// Bank of 256 decrementing timers with an Avalon-MM register slave
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module dstb_timer_bank
	import dstb_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES     // Clocks per 10 ms tick
) (
	input  wire logic        clk_sys,             // System clock, 10 MHz
	input  wire logic        rst_n,               // Async reset, low
	input  wire logic [7:0]  avs_address,         // Byte address
	input  wire logic        avs_read,            // Read request
	input  wire logic        avs_write,           // Write request
	input  wire logic [31:0] avs_writedata,       // Write data
	input  wire logic [3:0]  avs_byteenable,      // Byte lanes
	output logic      [31:0] avs_readdata,        // Read data
	output logic             avs_waitrequest,     // Stall
	input  wire logic        power_restore        // Pin, high once power is back
);

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// True when every nibble is a decimal digit
	function automatic logic is_bcd(input logic [15:0] v);
		is_bcd = (v[15:12] < 4'hA) && (v[11:8] < 4'hA) && (v[7:4] < 4'hA) && (v[3:0] < 4'hA);
	endfunction

	// Four BCD digits to binary
	function automatic logic [15:0] bcd_to_bin(input logic [15:0] v);
		bcd_to_bin = 16'(16'(v[15:12]) * 16'h03E8) + 16'(16'(v[11:8]) * 16'h0064)
			+ 16'(16'(v[7:4]) * 16'h000A) + 16'(v[3:0]);
	endfunction

	// Binary up to 9999 to four BCD digits
	function automatic logic [15:0] bin_to_bcd(input logic [15:0] b);
		logic [15:0] d3, d2, d1, d0;
		d3 = b / 16'h03E8;
		d2 = (b / 16'h0064) % 16'h000A;
		d1 = (b / 16'h000A) % 16'h000A;
		d0 = b % 16'h000A;
		bin_to_bcd = {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
	endfunction

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Storage and registers
	logic [15:0]          pv_r       [TIMER_COUNT];   // present_value per timer
	logic [15:0]          pv_nxt     [TIMER_COUNT];
	logic [15:0]          stamp_r    [TIMER_COUNT];   // Tick count of last refresh
	logic [15:0]          stamp_nxt  [TIMER_COUNT];
	logic [TIMER_COUNT-1:0] done_r, done_nxt;       // Completion flags
	logic [TIMER_COUNT-1:0] run_r, run_nxt;         // Input seen high, timing
	logic [TIMER_COUNT-1:0] reload_r, reload_nxt;   // Reload set value next run
	logic [CTRL_W-1:0]    ctrl_r, ctrl_nxt;         // Control register
	logic [15:0]          sv_r, sv_nxt;             // set_value register
	logic [15:0]          stat_pv_r, stat_pv_nxt;   // Last result present value
	logic                 stat_done_r, stat_done_nxt;
	logic                 stat_err_r, stat_err_nxt; // error_flag
	logic [2:0]           sync_r, sync_nxt;         // Pin synchroniser
	logic                 filt_r, filt_nxt;         // Filtered pin level
	dstb_bus_type         bus_r, bus_nxt;           // Bus handshake state
	logic                 wait_r, wait_nxt;         // waitrequest flop
	logic [31:0]          rdata_r, rdata_nxt;       // readdata flop
	logic [15:0]          now_ticks;                // Time base
	logic                 wr_fire;                  // Write takes effect
	logic                 cmd_fire;                 // Full-word command write
	logic                 exec_fire;                // Timer execution
	logic [NUM_W-1:0]     cmd_idx;                  // Selected timer
	dstb_op_type          cmd_op;                   // Instruction code
	logic                 cmd_input, cmd_binary, cmd_tenms, cmd_ilock, cmd_jump;
	logic [15:0]          cur_pv, cur_stamp;        // Selected timer state
	logic                 cur_done, cur_run, cur_reload;
	logic                 exec_err;                 // Set value not BCD in BCD mode
	logic                 pwr_rise;                 // Power restored event
	logic                 hold_on;                  // Hold bit set and protected
	logic [15:0]          elapsed, units, consumed, dec_pv;
	logic [15:0]          res_pv;                   // Result for selected timer
	logic                 res_done;

	////////////////////////////////////////////////////////////////////////////////
	// Time base
	dstb_tick_base #(
		.CYCLES     (TICK_CYCLES_P)
	) u_tick (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.tick_count (now_ticks)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Power pin synchroniser; a level counts once stages two and three agree
	always_comb begin
		sync_nxt = {sync_r[1:0], power_restore};
		filt_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : filt_r;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_r <= 3'h0;
			filt_r <= 1'b0;
		end else begin
			sync_r <= sync_nxt;
			filt_r <= filt_nxt;
		end
	end

	assign pwr_rise = sync_r[1] && sync_r[2] && !filt_r;

	////////////////////////////////////////////////////////////////////////////////
	// Avalon handshake: one wait cycle, then waitrequest low for one cycle
	always_comb begin
		bus_nxt   = bus_r;
		rdata_nxt = rdata_r;
		case (bus_r)
			BUS_WAIT: begin
				if (avs_read || avs_write) begin
					bus_nxt = BUS_ACK;
					case (avs_address)
						OFS_CTRL:   rdata_nxt = {29'h0, ctrl_r};
						OFS_SETVAL: rdata_nxt = {16'h0, sv_r};
						OFS_STATUS: rdata_nxt = {14'h0, stat_err_r, stat_done_r, stat_pv_r};
						OFS_TICK:   rdata_nxt = {16'h0, now_ticks};
						default:    rdata_nxt = 32'h0;  // Command and unmapped read zero
					endcase
				end
			end
			BUS_ACK: bus_nxt = BUS_WAIT;
			default: bus_nxt = BUS_WAIT;
		endcase
		wait_nxt = (bus_nxt != BUS_ACK);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_r   <= BUS_WAIT;
			wait_r  <= 1'b1;
			rdata_r <= 32'h0;
		end else begin
			bus_r   <= bus_nxt;
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;

	////////////////////////////////////////////////////////////////////////////////
	// Command decode
	assign wr_fire    = avs_write && (bus_r == BUS_ACK);
	assign cmd_fire   = wr_fire && (avs_address == OFS_CMD) && (avs_byteenable == BE_ALL);
	assign cmd_idx    = avs_writedata[CMD_NUM_LSB +: NUM_W];
	assign cmd_op     = dstb_op_type'(avs_writedata[CMD_OP_LSB +: CMD_OP_W]);
	assign cmd_input  = avs_writedata[CMD_INPUT_BIT];
	assign cmd_binary = avs_writedata[CMD_BINARY_BIT];
	assign cmd_tenms  = avs_writedata[CMD_TENMS_BIT];
	assign cmd_ilock  = avs_writedata[CMD_ILOCK_BIT];
	assign cmd_jump   = avs_writedata[CMD_JUMP_BIT];
	assign exec_fire  = cmd_fire && (cmd_op == OP_EXECUTE);
	assign cur_pv     = pv_r[cmd_idx];
	assign cur_stamp  = stamp_r[cmd_idx];
	assign cur_done   = done_r[cmd_idx];
	assign cur_run    = run_r[cmd_idx];
	assign cur_reload = reload_r[cmd_idx];
	assign exec_err   = !cmd_binary && !is_bcd(sv_r);
	assign hold_on    = ctrl_r[CTRL_HOLD_BIT] && ctrl_r[CTRL_PROT_BIT];

	// Elapsed ticks since last refresh; 16-bit wrap is safe for scans up to 655 s
	assign elapsed  = now_ticks - cur_stamp;
	assign units    = cmd_tenms ? elapsed : (elapsed / TICKS_PER_UNIT_W);
	// Leftover ticks stay in the stamp, so expiry is early by under one tick
	assign consumed = cmd_tenms ? elapsed : 16'(units * TICKS_PER_UNIT_W);
	// Saturating countdown in the timer's own coding
	assign dec_pv   = cmd_binary ? ((cur_pv > units) ? (cur_pv - units) : PV_ZERO)
		: bin_to_bcd((bcd_to_bin(cur_pv) > units) ? (bcd_to_bin(cur_pv) - units) : PV_ZERO);

	////////////////////////////////////////////////////////////////////////////////
	// Timer bank and register next state
	always_comb begin
		pv_nxt        = pv_r;
		stamp_nxt     = stamp_r;
		done_nxt      = done_r;
		run_nxt       = run_r;
		reload_nxt    = reload_r;
		ctrl_nxt      = ctrl_r;
		sv_nxt        = sv_r;
		stat_pv_nxt   = stat_pv_r;
		stat_done_nxt = stat_done_r;
		stat_err_nxt  = stat_err_r;
		res_pv        = cur_pv;
		res_done      = cur_done;
		// Power restored, hold not protected: every timer back to its set value at next run
		if (pwr_rise && !hold_on) begin
			for (int i = 0; i < TIMER_COUNT; i++) begin
				pv_nxt[i]     = PV_ZERO;
				done_nxt[i]   = 1'b0;
				run_nxt[i]    = 1'b0;
				reload_nxt[i] = 1'b1;
			end
		end
		// Control write; a change of operating mode clears the bank unless the hold bit is set
		if (wr_fire && (avs_address == OFS_CTRL)) begin
			ctrl_nxt = CTRL_W'(merge({29'h0, ctrl_r}, avs_writedata, avs_byteenable));
			if ((ctrl_nxt[CTRL_RUN_BIT] != ctrl_r[CTRL_RUN_BIT]) && !ctrl_r[CTRL_HOLD_BIT]) begin
				for (int i = 0; i < TIMER_COUNT; i++) begin
					pv_nxt[i]   = PV_ZERO;
					done_nxt[i] = 1'b0;
					run_nxt[i]  = 1'b0;
				end
			end
		end
		// Set value write
		if (wr_fire && (avs_address == OFS_SETVAL)) begin
			sv_nxt = 16'(merge({16'h0, sv_r}, avs_writedata, avs_byteenable));
		end
		// Instruction launch on a full-word command write
		if (cmd_fire) begin
			stat_err_nxt = 1'b0;
			case (cmd_op)
				OP_EXECUTE: begin
					stat_err_nxt = exec_err;
					if (exec_err || cmd_jump) begin
						// Bad operand or skipped section: state untouched
						res_pv   = cur_pv;
						res_done = cur_done;
					end else if (cmd_ilock || !cmd_input) begin
						// Reset state while input low or interlocked
						res_pv                = sv_r;
						res_done              = 1'b0;
						run_nxt[cmd_idx]      = 1'b0;
						reload_nxt[cmd_idx]   = 1'b0;
					end else if (!cur_run || cur_reload) begin
						// Start from the set value on a rising input
						res_pv                = sv_r;
						res_done              = (sv_r == PV_ZERO);
						stamp_nxt[cmd_idx]    = now_ticks;
						run_nxt[cmd_idx]      = 1'b1;
						reload_nxt[cmd_idx]   = 1'b0;
					end else if (cur_pv != PV_ZERO) begin
						// Count down, flag refreshed from the new present value
						res_pv                = dec_pv;
						res_done              = (dec_pv == PV_ZERO);
						stamp_nxt[cmd_idx]    = cur_stamp + consumed;
					end else begin
						// Timed out: hold zero and flag
						res_pv   = PV_ZERO;
						res_done = 1'b1;
					end
				end
				OP_RESET_INSTR: begin
					res_pv                = cmd_binary ? BIN_MAX : BCD_MAX;
					res_done              = 1'b0;
					reload_nxt[cmd_idx]   = 1'b1;
				end
				OP_FORCE_SET: begin
					res_pv   = PV_ZERO;
					res_done = 1'b1;
				end
				OP_FORCE_RESET: begin
					res_pv             = sv_r;
					res_done           = 1'b0;
					stamp_nxt[cmd_idx] = now_ticks;
				end
				OP_MOVE_WORD: begin
					// Non-zero value written while timing restarts the countdown
					res_pv             = sv_r;
					stamp_nxt[cmd_idx] = now_ticks;
				end
				OP_QUERY: begin
					res_pv   = cur_pv;
					res_done = cur_done;
				end
				default: begin
					res_pv   = cur_pv;
					res_done = cur_done;
				end
			endcase
			pv_nxt[cmd_idx]   = res_pv;
			done_nxt[cmd_idx] = res_done;
			stat_pv_nxt       = res_pv;
			stat_done_nxt     = res_done;
		end
	end

	// Register the bank; reset leaves PV zero and flags off
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < TIMER_COUNT; i++) begin
				pv_r[i]    <= PV_ZERO;
				stamp_r[i] <= PV_ZERO;
			end
			done_r      <= '0;
			run_r       <= '0;
			reload_r    <= '0;
			ctrl_r      <= CTRL_RESET;
			sv_r        <= PV_ZERO;
			stat_pv_r   <= PV_ZERO;
			stat_done_r <= 1'b0;
			stat_err_r  <= 1'b0;
		end else begin
			pv_r        <= pv_nxt;
			stamp_r     <= stamp_nxt;
			done_r      <= done_nxt;
			run_r       <= run_nxt;
			reload_r    <= reload_nxt;
			ctrl_r      <= ctrl_nxt;
			sv_r        <= sv_nxt;
			stat_pv_r   <= stat_pv_nxt;
			stat_done_r <= stat_done_nxt;
			stat_err_r  <= stat_err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Request always answered after one wait cycle
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered in one cycle");
	ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	bcd_error_a: assert property (exec_fire |=> stat_err_r == $past(exec_err))
		else $error("error flag does not match set value coding");
	input_low_a: assert property (exec_fire && !exec_err && !cmd_jump && !cmd_input
		|=> stat_pv_r == $past(sv_r) && !stat_done_r)
		else $error("low input did not reset timer");
	zero_start_a: assert property (exec_fire && !exec_err && !cmd_jump && !cmd_ilock && cmd_input
		&& !cur_run && sv_r == PV_ZERO |=> stat_done_r)
		else $error("zero set value did not time out at start");
	done_refresh_a: assert property (exec_fire && !exec_err && !cmd_jump && cmd_input && !cmd_ilock
		|=> stat_done_r == (stat_pv_r == PV_ZERO))
		else $error("completion flag disagrees with present value");
	jump_keep_a: assert property (exec_fire && cmd_jump && !exec_err
		|=> stat_pv_r == $past(cur_pv) && stat_done_r == $past(cur_done))
		else $error("jumped timer changed state");
	reset_instr_a: assert property (cmd_fire && cmd_op == OP_RESET_INSTR
		|=> !stat_done_r && stat_pv_r == ($past(cmd_binary) ? BIN_MAX : BCD_MAX))
		else $error("reset instruction loaded wrong value");
	force_set_a: assert property (cmd_fire && cmd_op == OP_FORCE_SET |=> stat_done_r && stat_pv_r == PV_ZERO)
		else $error("forced set did not zero the timer");

endmodule // dstb_timer_bank

/* File: dstb_scan_prog.sv */
// Scan program model: Avalon-MM master that issues register accesses
`timescale 1ns/1ps
module dstb_scan_prog (
	input  wire logic        clk_sys,          // System clock
	input  wire logic [31:0] avs_readdata,     // Read data
	input  wire logic        avs_waitrequest,  // Stall
	output logic      [7:0]  avs_address,      // Byte address
	output logic             avs_read,         // Read request
	output logic             avs_write,        // Write request
	output logic      [31:0] avs_writedata,    // Write data
	output logic      [3:0]  avs_byteenable    // Byte lanes, all four
);
	// Idle bus from time zero
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
	end
	// One access at a time, so no timer number runs twice at once
	// Accesses are short, keeping every scan far below the limit
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		// Hold the request until waitrequest is seen low
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
endmodule // dstb_scan_prog

/* File: tb.sv */
// Self-checking bench of the scan timer bank
`timescale 1ns/1ps
module tb;
	import dstb_pkg::*;
	localparam int TC = 10;                   // Clocks per tick in sim
	localparam int UC = TC * TICKS_PER_UNIT;  // Clocks per 100 ms unit
	localparam logic [4:0] F_IN = 5'h01;      // Start input
	localparam logic [4:0] F_BIN = 5'h02;     // Binary mode
	localparam logic [4:0] F_TEN = 5'h04;     // Ten ms variant
	localparam logic [4:0] F_LOCK = 5'h08;    // Interlocked
	localparam logic [4:0] F_SKIP = 5'h10;    // Jumped
	logic        clk_sys = 1'b0;              // System clock
	logic        rst_n = 1'b0;                // Reset, low
	logic        power_restore = 1'b0;        // Power pin
	logic [7:0]  adr;                         // Bus address
	logic        rd;                          // Bus read
	logic        wr;                          // Bus write
	logic [31:0] wd;                          // Bus write data
	logic [3:0]  be;                          // Bus lanes
	logic [31:0] rdat;                        // Bus read data
	logic        wait_r;                      // Bus stall
	int          mismatches = 0;              // Failed compares
	int          total_checks = 0;            // All compares
	int          cyc = 0;                     // Clock count
	dstb_timer_bank #(.TICK_CYCLES_P(TC)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wait_r), .power_restore(power_restore));
	dstb_scan_prog prog (.clk_sys(clk_sys), .avs_readdata(rdat), .avs_waitrequest(wait_r), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be));
	// 10 MHz clock
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	// Verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	// Compare seen against expected
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Expected status word
	function automatic logic [31:0] sw(input logic [15:0] pv, input logic dn, input logic er);
		return {14'h0000, er, dn, pv};
	endfunction
	// Write the set value
	task automatic setv(input logic [15:0] v);
		logic [31:0] q;
		prog.acc(1'b1, OFS_SETVAL, {16'h0000, v}, q);
	endtask
	// Issue an instruction, then read the status word
	task automatic run(input logic [7:0] n, input logic [4:0] f, output logic [31:0] s,
		input dstb_op_type op = OP_EXECUTE);
		prog.acc(1'b1, OFS_CMD, {13'h0000, op, 3'h0, f, n}, s);
		prog.acc(1'b0, OFS_STATUS, 32'h00000000, s);
	endtask
	// Wait a number of clocks
	task automatic w(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	// Power restore pulse through the pin filter
	task automatic pwr;
		power_restore <= 1'b1;
		w(8);
		power_restore <= 1'b0;
		w(8);
	endtask
	// Main sequence
	initial begin
		logic [31:0] s;
		logic [15:0] v;
		logic [7:0]  n;
		int          u;
		void'($urandom(32'h2B7D0C10));
		w(12);
		rst_n <= 1'b1;
		prog.acc(1'b0, OFS_CTRL, 32'h00000000, s);
		chk(s, 32'h00000000);
		prog.acc(1'b0, 8'h14, 32'h00000000, s);
		chk(s, 32'h00000000);
		// Tick count advances 10 or 11 ticks over 103 clocks
		prog.acc(1'b0, OFS_TICK, 32'h00000000, s);
		v = s[15:0];
		w(UC);
		prog.acc(1'b0, OFS_TICK, 32'h00000000, s);
		chk({31'h00000000, (s[15:0] - v) inside {[16'h000A:16'h000B]}}, 32'h00000001);
		// Edge and random timer numbers count down in whole units
		for (int i = 0; i < 5; i++) begin
			// Random numbers stay clear of the fixed timers used below
			n = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom_range(254, 16));
			v = 16'($urandom_range(65535, 8));
			u = $urandom_range(3, 1);
			setv(v);
			run(n, F_BIN, s);
			chk(s, sw(v, 1'b0, 1'b0));
			run(n, F_BIN | F_IN, s);
			w(u * UC);
			run(n, F_BIN | F_IN, s);
			chk(s, sw(v - 16'(u), 1'b0, 1'b0));
		end
		setv(16'h0100);
		run(8'h07, 5'h00, s);
		run(8'h07, F_IN, s);
		w(UC);
		run(8'h07, F_IN, s);
		chk(s, sw(16'h0099, 1'b0, 1'b0));
		// Time-out, hold and restart by move
		setv(16'h0002);
		run(8'h09, 5'h00, s);
		run(8'h09, F_IN, s);
		w(3 * UC);
		run(8'h09, F_IN, s, OP_QUERY);
		chk(s, sw(16'h0002, 1'b0, 1'b0));
		run(8'h09, F_IN, s);
		chk(s, sw(16'h0000, 1'b1, 1'b0));
		w(UC);
		run(8'h09, F_IN, s);
		chk(s, sw(16'h0000, 1'b1, 1'b0));
		setv(16'h0005);
		run(8'h09, F_IN, s, OP_MOVE_WORD);
		run(8'h09, F_IN, s);
		chk(s, sw(16'h0005, 1'b0, 1'b0));
		// Zero set value times out at the starting execution
		setv(16'h0000);
		run(8'h0B, F_BIN, s);
		run(8'h0B, F_BIN | F_IN, s);
		chk(s, sw(16'h0000, 1'b1, 1'b0));
		// Non-BCD digit in BCD mode flags an error, binary does not
		setv(16'h12A4);
		run(8'h0C, F_IN, s);
		chk(32'(s[17]), 32'h00000001);
		run(8'h0C, F_IN | F_BIN, s);
		chk(s, sw(16'h12A4, 1'b0, 1'b0));
		// Reset instruction in both modes, then reload on start
		run(8'h0D, 5'h00, s, OP_RESET_INSTR);
		chk(s, sw(BCD_MAX, 1'b0, 1'b0));
		run(8'h0D, F_BIN, s, OP_RESET_INSTR);
		chk(s, sw(BIN_MAX, 1'b0, 1'b0));
		setv(16'h0003);
		run(8'h0D, F_IN, s);
		chk(s, sw(16'h0003, 1'b0, 1'b0));
		// Jumped section keeps state, interlock resets
		w(UC);
		run(8'h0D, F_IN | F_SKIP, s);
		chk(s, sw(16'h0003, 1'b0, 1'b0));
		run(8'h0D, F_IN, s);
		chk(s, sw(16'h0002, 1'b0, 1'b0));
		run(8'h0D, F_IN | F_LOCK, s);
		chk(s, sw(16'h0003, 1'b0, 1'b0));
		run(8'h0D, F_IN, s, OP_FORCE_SET);
		chk(s, sw(16'h0000, 1'b1, 1'b0));
		run(8'h0D, F_IN, s, OP_FORCE_RESET); // Flag cleared as after an online edit
		chk(s, sw(16'h0003, 1'b0, 1'b0));
		// Ten ms variant counts ticks, never late
		setv(16'h0032);
		run(8'h0E, F_TEN | F_BIN, s);
		run(8'h0E, F_TEN | F_BIN | F_IN, s);
		w(3 * UC);
		run(8'h0E, F_TEN | F_BIN | F_IN, s);
		chk({31'h00000000, s[15:0] inside {[16'h0013:16'h0014]}}, 32'h00000001);
		// Mode change clears without hold, keeps with hold
		prog.acc(1'b1, OFS_CTRL, 32'h00000004, s);
		run(8'h0E, F_BIN, s, OP_QUERY);
		chk(s, sw(16'h0000, 1'b0, 1'b0));
		prog.acc(1'b1, OFS_CTRL, 32'h00000005, s);
		setv(16'h0007);
		run(8'h0F, F_BIN | F_IN, s);
		prog.acc(1'b1, OFS_CTRL, 32'h00000001, s);
		run(8'h0F, F_BIN, s, OP_QUERY);
		chk(s, sw(16'h0007, 1'b0, 1'b0));
		// Power loss clears unless hold is protected
		pwr();
		run(8'h0F, F_BIN, s, OP_QUERY);
		chk(s, sw(16'h0000, 1'b0, 1'b0));
		run(8'h0F, F_BIN | F_IN, s);
		chk(s, sw(16'h0007, 1'b0, 1'b0));
		prog.acc(1'b1, OFS_CTRL, 32'h00000003, s);
		pwr();
		run(8'h0F, F_BIN, s, OP_QUERY);
		chk(s, sw(16'h0007, 1'b0, 1'b0));
		stop_test();
	end
endmodule // tb
